/* src/pdl_defs.svh */
// Constants for the duty-limited PWM controller slice.
`ifndef PDL_DEFS_SVH
`define PDL_DEFS_SVH
`define PDL_CLK_HZ        200000000
`define PDL_SW_HZ         500000
`define PDL_PERIOD_CYCLES (`PDL_CLK_HZ / `PDL_SW_HZ)
`define PDL_REG_COUNT     12
`define PDL_REG_DLC       4'h0
`define PDL_REG_NUM_BASE  1
`define PDL_REG_DEN_BASE  9
`define PDL_DLC_RESET     8'hfc
`define PDL_I2C_ADDR      7'h2a
`define PDL_NUM_SHIFT     8
`define PDL_DEN_SHIFT     6
`define PDL_SAT_WINDOW    10'sh010
`define PDL_DUTY_SCALE    10'h040
`define PDL_CS_BIT_CYCLES 40
`define PDL_CS_SAMPLE     30
`define PDL_CS_BITS       8
`define PDL_CS_SHIFT      2
`endif

/* src/pdl_pkg.sv */
// Types shared by the duty-limited PWM controller slice.
package pdl_pkg;
   typedef struct packed {
      logic [5:0] duty_limit_field;
      logic       high_saturation_enable;
      logic       low_saturation_enable;
   } pdl_dlc_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_REG,
      ST_WR,
      ST_RD
   } pdl_i2c_st_t;
endpackage : pdl_pkg

/* src/pdl_top.sv */
// Duty-limited PWM generator with compensation filter, I2C registers and current share.
`timescale 1ns/10ps
`include "pdl_defs.svh"
module pdl_top (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rstn,
   // I2C management pins
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe,
   // Converter measurements from the ADC front end
   input  wire logic signed [7:0] adc_error,
   input  wire logic        [7:0] own_current,
   // Current share line, open drain
   input  wire logic              cs_in,
   output logic                   cs_out,
   output logic                   cs_oe,
   // Power stage drive
   output logic                   pwm_out,
   output logic             [5:0] duty_code
);
   localparam logic [8:0] PERIOD_M1 = 9'(`PDL_PERIOD_CYCLES - 1);

   logic                    rst_q1, rst_n;
   logic [1:0]              scl_s, sda_s, cs_s;
   logic                    scl_d, sda_d;
   logic [7:0]              err_s1, err_s2, cur_s1, cur_s2;
   logic [7:0]              regs [`PDL_REG_COUNT];
   pdl_pkg::pdl_dlc_t       dlc;
   pdl_pkg::pdl_i2c_st_t    st_reg;
   logic [3:0]              bit_cnt_reg;
   logic [7:0]              shift_reg, ptr_reg;
   logic                    ack_pend_reg;
   logic [7:0]              shift_next, rd_byte;
   logic                    scl_rise, scl_fall, i2c_start, i2c_stop;
   logic [8:0]              per_cnt_reg;
   logic                    upd;
   logic signed [15:0]      coef [4];
   logic signed [9:0]       ev [4];
   logic signed [7:0]       u_hist [1:3];
   logic signed [9:0]       ev_hist [1:3];
   logic [18:0]             pwm_lhs, pwm_rhs;
   logic signed [31:0]      acc_num, acc_den, u_calc;
   logic [5:0]              u_clamp, duty_next;
   logic signed [9:0]       e_now;
   logic                    sat_hi, sat_lo;
   logic [2:0]              cs_bit_reg;
   logic [5:0]              cs_cyc_reg;
   logic                    cs_active_reg, cs_contend_reg;
   logic [7:0]              cs_max_reg, cs_acc_reg, cs_tx_reg;

   localparam logic [5:0] CS_SAMPLE   = 6'(`PDL_CS_SAMPLE);
   localparam logic [5:0] CS_BIT_M1   = 6'(`PDL_CS_BIT_CYCLES - 1);
   localparam logic [2:0] CS_LAST_BIT = 3'(`PDL_CS_BITS - 1);

   // Reset release through two flip-flops.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_q1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n  <= rst_q1;
      end
   end

   // Pin synchronisers; the first stage feeds only the second.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_s  <= 2'h3;
         sda_s  <= 2'h3;
         cs_s   <= 2'h3;
         scl_d  <= 1'b1;
         sda_d  <= 1'b1;
         err_s1 <= 8'h00;
         err_s2 <= 8'h00;
         cur_s1 <= 8'h00;
         cur_s2 <= 8'h00;
      end else begin
         scl_s  <= {scl_s[0], scl_in};
         sda_s  <= {sda_s[0], sda_in};
         cs_s   <= {cs_s[0], cs_in};
         scl_d  <= scl_s[1];
         sda_d  <= sda_s[1];
         err_s1 <= adc_error;
         err_s2 <= err_s1;
         cur_s1 <= own_current;
         cur_s2 <= cur_s1;
      end
   end

   assign scl_rise   = scl_s[1] & ~scl_d;
   assign scl_fall   = ~scl_s[1] & scl_d;
   assign i2c_start  = scl_s[1] & scl_d & sda_d & ~sda_s[1];
   assign i2c_stop   = scl_s[1] & scl_d & ~sda_d & sda_s[1];
   assign shift_next = {shift_reg[6:0], sda_s[1]};
   assign rd_byte    = (ptr_reg < 8'(`PDL_REG_COUNT)) ? regs[ptr_reg[3:0]] : 8'h00;

   // I2C slave: address, register pointer, then auto-incrementing data.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg       <= pdl_pkg::ST_IDLE;
         bit_cnt_reg  <= 4'h0;
         shift_reg    <= 8'h00;
         ptr_reg      <= 8'h00;
         ack_pend_reg <= 1'b0;
         sda_oe       <= 1'b0;
         sda_out      <= 1'b0;
      end else if (i2c_start || i2c_stop) begin
         st_reg       <= i2c_start ? pdl_pkg::ST_ADDR : pdl_pkg::ST_IDLE;
         bit_cnt_reg  <= 4'h0;
         ack_pend_reg <= 1'b0;
         sda_oe       <= 1'b0;
      end else if (scl_rise && st_reg != pdl_pkg::ST_IDLE) begin
         if (bit_cnt_reg != 4'h8) begin
            shift_reg   <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h7) begin
               ack_pend_reg <= st_reg != pdl_pkg::ST_RD;
               unique case (st_reg)
                  pdl_pkg::ST_ADDR: begin
                     if (shift_next[7:1] != `PDL_I2C_ADDR) begin
                        st_reg       <= pdl_pkg::ST_IDLE;
                        ack_pend_reg <= 1'b0;
                     end else begin
                        st_reg <= shift_next[0] ? pdl_pkg::ST_RD : pdl_pkg::ST_REG;
                     end
                  end
                  pdl_pkg::ST_REG: begin
                     ptr_reg <= shift_next;
                     st_reg  <= pdl_pkg::ST_WR;
                  end
                  pdl_pkg::ST_WR: ptr_reg <= ptr_reg + 8'h01;
                  pdl_pkg::ST_RD: ;
                  pdl_pkg::ST_IDLE: ;
               endcase
            end
         end else begin
            bit_cnt_reg  <= 4'h0;
            ack_pend_reg <= 1'b0;
            if (st_reg == pdl_pkg::ST_RD) begin
               if (sda_s[1]) begin
                  st_reg <= pdl_pkg::ST_IDLE;
               end else begin
                  ptr_reg <= ptr_reg + 8'h01;
               end
            end
         end
      end else if (scl_fall) begin
         if (bit_cnt_reg == 4'h8) begin
            sda_oe <= ack_pend_reg;
         end else if (st_reg == pdl_pkg::ST_RD) begin
            sda_oe <= ~rd_byte[3'(4'h7 - bit_cnt_reg)];
         end else begin
            sda_oe <= 1'b0;
         end
      end
   end

   // Register file written by the host; out-of-range pointers are ignored.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `PDL_REG_COUNT; i++) begin
            regs[i] <= (i == 0) ? `PDL_DLC_RESET : 8'h00;
         end
      end else if (scl_rise && st_reg == pdl_pkg::ST_WR && bit_cnt_reg == 4'h7 &&
                   ptr_reg < 8'(`PDL_REG_COUNT)) begin
         regs[ptr_reg[3:0]] <= shift_next;
      end
   end

   assign dlc = regs[`PDL_REG_DLC];

   // Numerator coefficients are upper and lower byte pairs.
   for (genvar g = 0; g < 4; g++) begin : g_coef
      assign coef[g] = {regs[`PDL_REG_NUM_BASE + 2 * g],
                        regs[`PDL_REG_NUM_BASE + 2 * g + 1]};
   end

   // Switching period counter; the duty is refreshed once per period.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         per_cnt_reg <= 9'h000;
      end else begin
         per_cnt_reg <= (per_cnt_reg == PERIOD_M1) ? 9'h000 : per_cnt_reg + 9'h001;
      end
   end
   assign upd = per_cnt_reg == PERIOD_M1;

   // Share error pulls the weaker converter up toward the largest current.
   assign e_now = 10'($signed(err_s2)) +
                  (10'($signed({2'b00, cs_max_reg}) - $signed({2'b00, cur_s2})) >>> `PDL_CS_SHIFT);
   assign ev[0] = e_now;
   for (genvar g = 1; g < 4; g++) begin : g_ev
      assign ev[g] = ev_hist[g];
   end

   // Third order recursive filter; an integrator pole needs the first
   // denominator at minus one, and the lowpass pole comes from the rest.
   always_comb begin
      acc_num = 32'sh0;
      acc_den = 32'sh0;
      for (int k = 0; k < 4; k++) begin
         acc_num = acc_num + 32'(coef[k] * ev[k]);
      end
      for (int k = 1; k < 4; k++) begin
         acc_den = acc_den + 32'($signed(regs[`PDL_REG_DEN_BASE + k - 1]) * u_hist[k]);
      end
      u_calc = (acc_num >>> `PDL_NUM_SHIFT) - (acc_den >>> `PDL_DEN_SHIFT);
      if (u_calc < 32'sh0) begin
         u_clamp = 6'h00;
      end else if (u_calc > 32'($unsigned(dlc.duty_limit_field))) begin
         u_clamp = dlc.duty_limit_field;
      end else begin
         u_clamp = u_calc[5:0];
      end
   end

   // Window comparators around the setpoint.
   assign sat_hi    = dlc.high_saturation_enable && (e_now > `PDL_SAT_WINDOW);
   assign sat_lo    = dlc.low_saturation_enable && (e_now < -`PDL_SAT_WINDOW);
   assign duty_next = sat_hi ? dlc.duty_limit_field : (sat_lo ? 6'h00 : u_clamp);

   // Output histories hold the clamped output, which keeps the integrator from winding up.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         duty_code <= 6'h00;
         for (int k = 1; k < 4; k++) begin
            u_hist[k]  <= 8'sh00;
            ev_hist[k] <= 10'sh000;
         end
      end else if (upd) begin
         duty_code <= duty_next;
         u_hist[1] <= 8'(duty_next);
         u_hist[2] <= u_hist[1];
         u_hist[3] <= u_hist[2];
         ev_hist[1] <= e_now;
         ev_hist[2] <= ev_hist[1];
         ev_hist[3] <= ev_hist[2];
      end
   end

   duty_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
      upd |=> duty_code <= $past(dlc.duty_limit_field)) else $error("duty above limit");
   sat_high_a: assert property (@(posedge clk) disable iff (!rst_n)
      upd && sat_hi |=> duty_code == $past(dlc.duty_limit_field)) else $error("no high jump");
   sat_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      upd && sat_lo && !sat_hi |=> duty_code == 6'h00) else $error("no low jump");
   prop_path_a: assert property (@(posedge clk) disable iff (!rst_n)
      upd && !sat_hi && !sat_lo |=> duty_code == $past(u_clamp)) else $error("bad duty");
   period_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
      per_cnt_reg == PERIOD_M1 |=> per_cnt_reg == 9'h000) else $error("period overrun");

   // Duty in 64ths is spread over the period by comparing scaled counts, so no divider.
   assign pwm_lhs = 19'(per_cnt_reg) * 19'(`PDL_DUTY_SCALE);
   assign pwm_rhs = 19'(duty_code) * 19'(`PDL_PERIOD_CYCLES);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwm_out <= 1'b0;
      end else begin
         pwm_out <= pwm_lhs < pwm_rhs;
      end
   end

   pwm_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      upd && duty_next == 6'h00 |=> ##1 !pwm_out [*8]) else $error("pulse at zero duty");

   // Each period every converter sends its current, top bit first, pulling the line low
   // for a one. One that sends a zero but sees the line low has lost and falls silent,
   // so the wired line ends each frame carrying the largest current of the group.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_active_reg  <= 1'b0;
         cs_contend_reg <= 1'b0;
         cs_bit_reg     <= 3'h0;
         cs_cyc_reg     <= 6'h00;
         cs_tx_reg      <= 8'h00;
         cs_acc_reg     <= 8'h00;
         cs_max_reg     <= 8'h00;
         cs_oe          <= 1'b0;
         cs_out         <= 1'b0;
      end else if (upd) begin
         cs_active_reg  <= 1'b1;
         cs_contend_reg <= 1'b1;
         cs_bit_reg     <= 3'h0;
         cs_cyc_reg     <= 6'h00;
         cs_tx_reg      <= cur_s2;
         cs_oe          <= cur_s2[7];
      end else if (cs_active_reg) begin
         cs_cyc_reg <= cs_cyc_reg + 6'h01;
         if (cs_cyc_reg == CS_SAMPLE) begin
            cs_acc_reg <= {cs_acc_reg[6:0], ~cs_s[1]};
            if (!cs_s[1] && !cs_tx_reg[7]) begin
               cs_contend_reg <= 1'b0;
            end
         end
         if (cs_cyc_reg == CS_BIT_M1) begin
            cs_cyc_reg <= 6'h00;
            cs_tx_reg  <= {cs_tx_reg[6:0], 1'b0};
            cs_bit_reg <= cs_bit_reg + 3'h1;
            if (cs_bit_reg == CS_LAST_BIT) begin
               cs_active_reg <= 1'b0;
               cs_oe         <= 1'b0;
               cs_max_reg    <= cs_acc_reg;
            end else begin
               cs_oe <= cs_contend_reg & cs_tx_reg[6];
            end
         end
      end
   end

   share_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
      cs_oe |-> cs_active_reg && cs_contend_reg) else $error("share line driven out of frame");
endmodule : pdl_top

/* tb/pdl_share_partner.sv */
// Behavioural second converter sitting on the shared current-share line.
`timescale 1ns/10ps
module pdl_share_partner (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Shared line, pulled up when nobody drives it
   input  wire logic        cs_line,
   output logic             cs_pull,
   output logic      [15:0] low_cycles
);
   // It stays released, so every low level seen on the line comes from the device.
   // Load regulation is not modelled.
   assign cs_pull = 1'b0;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         low_cycles <= 16'h0000;
      end else if (!cs_line && low_cycles != 16'hffff) begin
         low_cycles <= low_cycles + 16'h0001;
      end
   end
endmodule : pdl_share_partner

/* tb/pdl_top_bench.sv */
// Self-checking bench for the duty-limited PWM slice.
`timescale 1ns/10ps
`include "pdl_defs.svh"
module pdl_top_bench;
   localparam int H = 25;
   localparam int P = `PDL_PERIOD_CYCLES;
   logic clk, rstn, scl, host_sda, sda_out, sda_oe, cs_out, cs_oe, cs_pull, pwm_out, mon_en;
   logic signed [7:0] adc_error;
   logic        [5:0] duty_code, lim_now;
   logic       [15:0] low_cycles;
   int                errors, comparisons;
   // Open-drain wires with pull-ups: low while any party drives low.
   wire logic sda_line = host_sda & ~(sda_oe & ~sda_out);
   wire logic cs_line  = ~cs_pull & ~(cs_oe & ~cs_out);
   pdl_top uut (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
                .sda_oe(sda_oe), .adc_error(adc_error), .own_current(8'h40), .cs_in(cs_line),
                .cs_out(cs_out), .cs_oe(cs_oe), .pwm_out(pwm_out), .duty_code(duty_code));
   pdl_share_partner partner (.clk(clk), .rstn(rstn), .cs_line(cs_line), .cs_pull(cs_pull),
                              .low_cycles(low_cycles));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (exp !== got) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic check_count(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (exp !== got) begin
         errors++;
         $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
      end
   endtask : check_count
   task automatic end_of_test;
      $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test
   // Duty must never pass the programmed limit while the limit is settled.
   always @(negedge clk) begin
      if (mon_en && duty_code > lim_now) begin
         check("duty within limit", 8'h01, 8'h00);
      end
   end
   task automatic i2c_bit(input logic b, output logic seen);
      @(negedge clk) scl = 1'b0;
      repeat (H) @(negedge clk);
      host_sda = b;
      repeat (H) @(negedge clk);
      scl = 1'b1;
      repeat (H) @(negedge clk);
      seen = sda_line;
   endtask : i2c_bit
   task automatic i2c_byte(input logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) i2c_bit(v[i], s);
      i2c_bit(1'b1, s);
      check("i2c ack", 8'h00, {7'h00, s});
   endtask : i2c_byte
   task automatic write_dlc(input pdl_pkg::pdl_dlc_t v);
      logic s;
      mon_en = 1'b0;
      repeat (H) @(negedge clk);
      host_sda = 1'b0;
      repeat (H) @(negedge clk);
      i2c_byte({`PDL_I2C_ADDR, 1'b0});
      i2c_byte({4'h0, `PDL_REG_DLC});
      i2c_byte(v);
      i2c_bit(1'b0, s);
      host_sda = 1'b1;
      lim_now = v.duty_limit_field;
      repeat (P) @(negedge clk);
      mon_en = 1'b1;
   endtask : write_dlc
   // Large errors of each sign; enabled saturation must reach zero or the limit.
   task automatic sat_case(input logic [5:0] lim, input logic hi, input logic lo);
      pdl_pkg::pdl_dlc_t v;
      logic [5:0] dp, dn;
      logic [15:0] n;
      v = '{duty_limit_field: lim, high_saturation_enable: hi, low_saturation_enable: lo};
      n = 16'h0000;
      write_dlc(v);
      adc_error = 8'sd100;
      repeat (P + 8) @(negedge clk);
      repeat (P) begin
         @(negedge clk);
         if (pwm_out === 1'b1) n = n + 16'h0001;
      end
      check_count("pwm high cycles", hi ? 16'((int'(lim) * P + 63) / 64) : 16'h0000, n);
      dp = duty_code;
      adc_error = -8'sd100;
      repeat (2 * P) @(negedge clk);
      dn = duty_code;
      adc_error = 8'sd0;
      repeat (2 * P) @(negedge clk);
      if (hi && lo) begin
         check("both ends", 8'h01, {7'h00, (dp === lim && dn === 6'h00)
                                          || (dp === 6'h00 && dn === lim)});
      end else if (hi) begin
         check("high end", 8'h01, {7'h00, dp === lim || dn === lim});
      end else begin
         check("low end", 8'h01, {7'h00, dp === 6'h00 || dn === 6'h00});
         check("high disabled", 8'h00, {2'b00, dp});
      end
      $display("Test saturation limit %h hi %b lo %b done", lim, hi, lo);
   endtask : sat_case
   task automatic share_case;
      repeat (4 * P) @(negedge clk);
      check("share line activity", 8'h01, {7'h00, low_cycles != 16'h0000});
      $display("Test current share done");
   endtask : share_case
   initial begin
      errors = 0;
      comparisons = 0;
      rstn = 1'b0;
      scl = 1'b1;
      host_sda = 1'b1;
      adc_error = 8'sd0;
      mon_en = 1'b0;
      lim_now = 6'h3f;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      mon_en = 1'b1;
      // Output is taken as low and steady, so saturation may stay on.
      sat_case(6'h3f, 1'b1, 1'b1);
      sat_case(6'h01, 1'b1, 1'b1);
      sat_case(6'h00, 1'b1, 1'b1);
      sat_case(6'h15, 1'b1, 1'b0);
      sat_case(6'h2a, 1'b0, 1'b1);
      share_case();
      end_of_test();
   end
   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      $display("[FAIL] watchdog expected done seen timeout");
      end_of_test();
   end
endmodule : pdl_top_bench
